// ===== dac_device.sv
/*
  Device end of the serial link: frame capture, command decode,
  channel registers, output update and power-down termination.
  Assumes link pins are asynchronous to pclk and sclk well below pclk/4.
*/
// The address map and the APB interface to the registers were chosen for this implementation.
// Function
// - output level equals reference times code over 256
// - frame select low shifts data on sclk falls
// - host never lowers select on sclk fall
// - sixteenth fall captures last bit, executes
// - edges after sixteenth fall are ignored
// - select high between frames; new frame on fall
// - host idles select and data low
// - first bit zero, second picks channel
// - mode bits choose among four operations
// - twelve data bits, msb first, straight binary
// - early select rise discards whole frame
// - reset clears registers, outputs zero
// - mode 11 powers down both channels
// - first two bits choose termination
// - power-down keeps channel register values
// - host idles lines and stops clock
`timescale 1ns/1ps
module dac_device (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  dac_link_if.device link,
  // analog side controls and frame result pulses
  output logic [7:0] code_a,
  output logic [7:0] code_b,
  output logic powered_down,
  output dac_link_pkg::term_t termination,
  output logic frame_done,
  output logic frame_error
);

  typedef struct packed {
    logic [1:0] sync_s;
    logic [1:0] sclk_s;
    logic [1:0] data_s;
    logic sclk_d;
    logic sync_d;
    logic active;
    logic [4:0] count;
    logic [15:0] shift;
    logic [7:0] input_a;
    logic [7:0] input_b;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic pd;
    dac_link_pkg::term_t term;
    logic done;
    logic err;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic [15:0] word;
  logic [7:0] code;
  dac_link_pkg::op_t op;

  assign sclk_fall = state_r.sclk_d & ~state_r.sclk_s[1];
  assign sync_fall = state_r.sync_d & ~state_r.sync_s[1];
  assign sync_rise = ~state_r.sync_d & state_r.sync_s[1];
  assign word = {state_r.shift[14:0], state_r.data_s[1]};
  // low data bits beyond the code width are dropped
  assign code = word[dac_link_pkg::POS_CODE_MSB:dac_link_pkg::POS_CODE_LSB];
  assign op = dac_link_pkg::op_t'(word[dac_link_pkg::POS_OP_HI:dac_link_pkg::POS_OP_LO]);

  // ----------------------------------------------------------------
  // frame capture and command execution
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.sync_s = {state_r.sync_s[0], link.sync_n};
    state_nxt.sclk_s = {state_r.sclk_s[0], link.sclk};
    state_nxt.data_s = {state_r.data_s[0], link.sdata};
    state_nxt.sclk_d = state_r.sclk_s[1];
    state_nxt.sync_d = state_r.sync_s[1];
    state_nxt.done = 1'b0;
    state_nxt.err = 1'b0;
    if (sync_fall) begin
      state_nxt.active = 1'b1;
      state_nxt.count = 5'h00;
    end else if (sync_rise && state_r.active) begin
      // partial frame: nothing committed
      state_nxt.active = 1'b0;
      // idle-low select opens an empty frame; only a cut frame is an error
      state_nxt.err = (state_r.count != 5'h00);
    end else if (state_r.active && !state_r.sync_s[1] && sclk_fall) begin
      state_nxt.shift = word;
      state_nxt.count = state_r.count + 5'h01;
      if (state_r.count + 5'h01 == dac_link_pkg::FRAME_LAST) begin
        // later edges fall outside an active frame
        state_nxt.active = 1'b0;
        state_nxt.done = 1'b1;
        if (op == dac_link_pkg::OP_POWER_DOWN) begin
          // registers kept as they are
          state_nxt.pd = 1'b1;
          state_nxt.term = dac_link_pkg::term_t'(word[15:14]);
        end else if (word[dac_link_pkg::POS_ZERO] == 1'b0) begin
          state_nxt.pd = 1'b0;
          case (op)
            dac_link_pkg::OP_LOAD_ONLY: begin
              if (word[dac_link_pkg::POS_CHAN]) state_nxt.input_b = code;
              else state_nxt.input_a = code;
            end
            dac_link_pkg::OP_LOAD_UPDATE: begin
              if (word[dac_link_pkg::POS_CHAN]) begin
                state_nxt.input_b = code;
                state_nxt.out_b = code;
                state_nxt.out_a = state_r.input_a;
              end else begin
                state_nxt.input_a = code;
                state_nxt.out_a = code;
                state_nxt.out_b = state_r.input_b;
              end
            end
            dac_link_pkg::OP_LOAD_BOTH: begin
              state_nxt.input_a = code;
              state_nxt.input_b = code;
              state_nxt.out_a = code;
              state_nxt.out_b = code;
            end
            default: begin
              state_nxt.pd = 1'b1;
            end
          endcase
        end else begin
          state_nxt.err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      state_r.sync_s <= 2'h3;
      state_r.sync_d <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // level is reference * code / 256, done in the analog string
  assign code_a = state_r.out_a;
  assign code_b = state_r.out_b;
  assign powered_down = state_r.pd;
  assign termination = state_r.term;
  assign frame_done = state_r.done;
  assign frame_error = state_r.err;

endmodule : dac_device

// ===== dac_host.sv
/*
  Host end of the serial link: APB slave holding a command word and a
  frame shifter that makes sclk from pclk by a divider.
  Assumes an APB master on pclk.
*/
`timescale 1ns/1ps
module dac_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  dac_link_if.host link
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_GAP = 2'h2
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [15:0] word;
    logic [4:0] bits;
    logic [7:0] div;
    logic [7:0] gap;
    logic sclk;
    logic sync_n;
    logic sdata;
    logic busy;
    logic abort_req;
    logic [15:0] sent;
    logic [31:0] rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic wr;
  logic rd;
  logic tick;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign tick = (state_r.div == 8'(dac_link_pkg::SCLK_HALF_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    state_nxt.div = tick ? 8'h00 : state_r.div + 8'h01;
    if (rd) begin
      case (paddr)
        dac_link_pkg::REG_STATUS: state_nxt.rdata = {15'h0000, state_r.busy, state_r.sent};
        dac_link_pkg::REG_CMD: state_nxt.rdata = {16'h0000, state_r.word};
        default: state_nxt.rdata = 32'h0000_0000;
      endcase
    end
    case (state_r.phase)
      ST_IDLE: begin
        // idle select and data low to save buffer current; sclk rests high
        state_nxt.sync_n = 1'b0;
        state_nxt.sdata = 1'b0;
        state_nxt.sclk = 1'b1;
        if (wr && paddr == dac_link_pkg::REG_CMD && !state_r.busy) begin
          state_nxt.word = pwdata[15:0];
          state_nxt.busy = 1'b1;
          state_nxt.sync_n = 1'b1;
          state_nxt.gap = 8'h00;
          state_nxt.phase = ST_GAP;
          state_nxt.bits = 5'h00;
          state_nxt.abort_req = 1'b0;
        end
      end
      ST_GAP: begin
        if (tick) begin
          if (state_r.gap >= 8'(dac_link_pkg::SYNC_HIGH_CYC)) begin
            // lower select while sclk is high, away from a fall
            state_nxt.sync_n = 1'b0;
            state_nxt.sdata = state_r.word[15];
            state_nxt.phase = ST_SHIFT;
          end else begin
            state_nxt.gap = state_r.gap + 8'h01;
          end
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          if (state_r.sclk) begin
            state_nxt.sclk = 1'b0;
            state_nxt.bits = state_r.bits + 5'h01;
          end else if (state_r.bits == dac_link_pkg::FRAME_LAST || state_r.abort_req) begin
            state_nxt.sclk = 1'b1;
            state_nxt.sync_n = 1'b1;
            state_nxt.busy = 1'b0;
            state_nxt.sent = state_r.word;
            state_nxt.phase = ST_IDLE;
          end else begin
            state_nxt.sclk = 1'b1;
            state_nxt.sdata = state_r.word[4'(15 - state_r.bits)];
          end
        end
      end
      default: state_nxt.phase = ST_IDLE;
    endcase
    if (wr && paddr == dac_link_pkg::REG_CTRL && pwdata[0]) begin
      state_nxt.abort_req = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      state_r.sclk <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.sclk = state_r.sclk;
  assign link.sync_n = state_r.sync_n;
  assign link.sdata = state_r.sdata;
  assign prdata = state_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

endmodule : dac_host

// ===== dac_link_asserts.sv
/*
  Checker for the serial write link and the device result pulses.
  Assumes it is instantiated beside the link, in the pclk domain.
*/
`timescale 1ns/1ps
module dac_link_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires and device pulses
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame_done,
  input wire logic frame_error
);
  // ------------------------------
  // falls seen since the select fell
  // ------------------------------
  logic [4:0] cnt_r;
  logic sclk_r;
  logic sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 5'h0;
      sclk_r <= 1'b1;
      sync_r <= 1'b0;
    end else begin
      sclk_r <= sclk;
      sync_r <= sync_n;
      if (sync_r && !sync_n) begin
        cnt_r <= 5'h0;
      end else if (!sync_n && sclk_r && !sclk && cnt_r != 5'h1F) begin
        cnt_r <= cnt_r + 5'h1;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------
  // properties
  // ------------------------------
  a_low_half: assert property ($fell(sclk) && cnt_r < 5'hF |-> ##1 (!sclk || sync_n) [*3])
    else $error("sclk low phase too short");
  a_high_half: assert property ($rose(sclk) && !sync_n && cnt_r < 5'h10 |-> sclk [*4])
    else $error("sclk high phase too short");
  a_data_steady: assert property
    ($changed(sdata) && !sync_n && !$past(sync_n) && cnt_r < 5'h10 |-> sclk)
    else $error("data moved while sclk low");
  a_start_high: assert property ($fell(sync_n) |-> sclk && !$fell(sclk))
    else $error("select fell on sclk fall");
  a_gap_bounded: assert property ($rose(sync_n) |-> ##[1:8] !sync_n)
    else $error("select not back to idle low");
  a_no_extra: assert property (!sync_n |-> cnt_r <= 5'h10)
    else $error("more than sixteen falls");
  a_done_cause: assert property (frame_done |-> cnt_r == 5'h10)
    else $error("done without sixteen falls");
  a_result_soon: assert property
    ($fell(sclk) && !sync_n && cnt_r == 5'hF |-> ##[1:8] (frame_done || frame_error))
    else $error("no result after last fall");
  a_early_abort: assert property
    ($rose(sync_n) && cnt_r != 5'h0 && cnt_r < 5'h10 |-> ##[0:8] frame_error)
    else $error("early rise not flagged");
  c_full: cover property ($rose(sync_n) && cnt_r == 5'h10);
  c_cut: cover property ($rose(sync_n) && cnt_r != 5'h0 && cnt_r < 5'h10);
  c_err: cover property (frame_error);
endmodule : dac_link_asserts

// ===== dac_link_if.sv
/*
  Three-wire serial write link between the host and the converter.
  Assumes the bench joins one host end and one device end.
*/
`timescale 1ns/1ps
interface dac_link_if;
  logic sync_n;
  logic sclk;
  logic sdata;

  modport host (output sync_n, output sclk, output sdata);
  modport device (input sync_n, input sclk, input sdata);
endinterface : dac_link_if

// ===== dac_link_pkg.sv
/*
  Shared constants for the dual 8-bit converter serial write link:
  frame layout, operation codes, termination codes and link timing.
  Assumes both ends run on pclk at 20 MHz.
*/
package dac_link_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int DATA_BITS = 12;
  localparam int POS_ZERO = 15;
  localparam int POS_CHAN = 14;
  localparam int POS_OP_HI = 13;
  localparam int POS_OP_LO = 12;
  localparam int POS_CODE_MSB = 11;
  localparam int POS_CODE_LSB = 4;
  localparam logic [4:0] FRAME_LAST = 5'h10;

  // ----------------------------------------------------------------
  // operation and termination codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_LOAD_ONLY = 2'h0,
    OP_LOAD_UPDATE = 2'h1,
    OP_LOAD_BOTH = 2'h2,
    OP_POWER_DOWN = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    TERM_HIZ = 2'h0,
    TERM_2K5 = 2'h1,
    TERM_100K = 2'h2,
    TERM_HIZ_ALT = 2'h3
  } term_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // least frame select high time between frames
  localparam int SYNC_HIGH_NS = 10;
  localparam int SYNC_HIGH_CYC_RAW = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_CYC_RAW < 1) ? 1 : SYNC_HIGH_CYC_RAW;
  // serial clock half period produced by the host divider
  localparam int SCLK_HALF_CYC = 4;
  // host apb register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;

endpackage : dac_link_pkg

// ===== dual_dac_serial_write_control_test.sv
/*
  Bench: apb master drives the host, the host drives the device.
  Assumes pclk 20 MHz and the host register map of the package.
*/
`timescale 1ns/1ps
module dual_dac_serial_write_control_test;
  typedef struct packed {
    logic err;
    logic [7:0] a;
    logic [7:0] b;
    logic pd;
    logic [1:0] term;
  } note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic powered_down, frame_done, frame_error, g;
  logic [7:0] paddr, code_a, code_b, in_a, in_b;
  logic [31:0] pwdata, prdata, q;
  dac_link_pkg::term_t termination;
  note_t cur, mn;
  note_t exp_q[$];
  int n_errors, checks, i;
  dac_link_if link();
  dac_host u_dac_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  dac_device u_dac_device (.pclk(pclk), .presetn(presetn), .link(link), .code_a(code_a),
    .code_b(code_b), .powered_down(powered_down), .termination(termination),
    .frame_done(frame_done), .frame_error(frame_error));
  dac_link_asserts u_dac_link_asserts (.pclk(pclk), .presetn(presetn), .sync_n(link.sync_n),
    .sclk(link.sclk), .sdata(link.sdata), .frame_done(frame_done), .frame_error(frame_error));
  // ------------------------------
  // helpers
  // ------------------------------
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch t=%0t %s", $time, msg);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // model first, then the frame; the monitor pops the note
  task send(input logic [15:0] w, input logic abort);
    note_t n;
    int k;
    n = cur;
    n.err = abort | (w[15] & (w[13:12] != 2'h3));
    if (!n.err) begin
      n.pd = (w[13:12] == 2'h3);
      case (w[13:12])
        2'h0: if (w[14]) in_b = w[11:4]; else in_a = w[11:4];
        2'h1: begin
          if (w[14]) in_b = w[11:4]; else in_a = w[11:4];
          n.a = in_a;
          n.b = in_b;
        end
        2'h2: begin
          in_a = w[11:4];
          in_b = w[11:4];
          n.a = in_a;
          n.b = in_b;
        end
        default: n.term = w[15:14];
      endcase
      cur = n;
    end
    exp_q.push_back(n);
    apb(1'b1, dac_link_pkg::REG_CMD, {16'h0, w}, q);
    if (abort) apb(1'b1, dac_link_pkg::REG_CTRL, 32'h1, q);
    while (exp_q.size() != 0) @(posedge pclk);
    q = 32'hFFFFFFFF;
    for (k = 0; k < 50 && q[16] !== 1'b0; k++) apb(1'b0, dac_link_pkg::REG_STATUS, 32'h0, q);
    chk(q[15:0] === w, "status word");
  endtask : send
  task final_report();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ------------------------------
  // clock, monitor, watchdog
  // ------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (frame_done === 1'b1 || frame_error === 1'b1) begin
      g = frame_error;
      repeat (2) @(negedge pclk);
      if (exp_q.size() == 0) chk(1'b0, "unexpected result");
      else begin
        mn = exp_q.pop_front();
        chk(g === mn.err, "done or error");
        chk(code_a === mn.a && code_b === mn.b, "codes");
        chk(powered_down === mn.pd, "power state");
        if (mn.pd) chk(termination === mn.term, "termination");
      end
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    chk(1'b0, "timeout");
    final_report();
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    cur = '0;
    in_a = 8'h00;
    in_b = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    q = 32'($urandom(32'h6F697067));
    chk(code_a === 8'h00 && code_b === 8'h00 && powered_down === 1'b0, "reset");
    apb(1'b0, 8'h0C, 32'h0, q);
    chk(q === 32'h0 && pslverr === 1'b0, "unmapped read");
    for (i = 0; i < 12; i++) send({1'b0, 1'($urandom), 2'(i % 3), 12'($urandom)}, 1'b0);
    send(16'h2FF5, 1'b0);
    send(16'h200A, 1'b0);
    for (i = 0; i < 4; i++) begin
      send({2'(i), 2'h3, 12'($urandom)}, 1'b0);
      send({1'b0, 1'($urandom), 2'(i % 3), 12'($urandom)}, 1'b0);
    end
    send(16'h9AB0, 1'b0);
    send(16'h1550, 1'b1);
    final_report();
  end
endmodule : dual_dac_serial_write_control_test
